// File: inc/pbf_pkg.sv
package pbf_pkg;
    localparam int          AW           = 12;
    localparam logic [3:0]  OFF_TCR      = 4'h0;
    localparam logic [3:0]  OFF_BSR_LO   = 4'he;
    localparam logic [3:0]  OFF_BSR_HI   = 4'hf;
    localparam logic [2:0]  BANK_TX      = 3'h0;
    localparam logic [2:0]  BANK_MT      = 3'h3;
    localparam logic [2:0]  BANK_EXT     = 3'h7;
    localparam logic [2:0]  BANK_RST     = 3'h0;
    localparam logic [7:0]  BSR_ID       = 8'h33;
    localparam logic [15:0] TCR_RST      = 16'h0000;
    localparam logic [15:0] TCR_MASK     = 16'hbd87;
    localparam int          TCR_CRC_SUPPRESS    = 8;
    localparam int          CTL_ODD      = 5;
    localparam int          CTL_CRC      = 4;
    localparam logic [7:0]  RX_CTL_BASE  = 8'h40;
    localparam logic [AW-1:0] W_STAT     = 12'h000;
    localparam logic [AW-1:0] W_CNT      = 12'h001;
    localparam logic [AW-1:0] W_DATA     = 12'h002;
    localparam logic [10:0] HDR_WORDS    = 11'h003;
    localparam logic [11:0] DATA_MAX     = 12'd2043;
    localparam logic [11:0] LEN_MAX      = 12'd1518;
    localparam logic [11:0] LEN_MIN      = 12'd64;
    localparam logic [11:0] DA_LEN       = 12'd6;
    localparam logic [11:0] HDR_ODD      = 12'd5;
    localparam logic [11:0] HDR_EVEN     = 12'd6;
    localparam logic [31:0] CRC_INIT     = 32'hffffffff;
    localparam logic [31:0] CRC_POLY     = 32'hedb88320;
    localparam logic [31:0] CRC_RES      = 32'hdebb20e3;
    localparam int          ST_ALGN      = 15;
    localparam int          ST_BCAST     = 14;
    localparam int          ST_CRC_ERROR_FLAG    = 13;
    localparam int          ST_ODD       = 12;
    localparam int          ST_LONG      = 11;
    localparam int          ST_SHORT     = 10;
    localparam int          ST_HASH      = 1;
    localparam int          ST_MCAST     = 0;

    typedef enum logic [2:0] {
        RX_IDLE,
        RX_DATA,
        RX_CTL,
        RX_CNT,
        RX_STAT
    } pbf_rx_state_type;

    typedef enum logic [3:0] {
        TX_IDLE,
        TX_CNT,
        TX_CTL,
        TX_NEXT,
        TX_WORD,
        TX_LO,
        TX_HI,
        TX_ODD,
        TX_CRC,
        TX_STAT
    } pbf_tx_state_type;
endpackage

// File: inc/pbf_crc_if.sv
`timescale 1ns/100ps
`default_nettype none
interface pbf_crc_if;
    logic        init;
    logic        en;
    logic [7:0]  data;
    logic [31:0] crc;
    modport user   (output init, output en, output data, input crc);
    modport engine (input init, input en, input data, output crc);
endinterface
`default_nettype wire

// File: hw/pbf_crc.sv
`timescale 1ns/100ps
`default_nettype none
module pbf_crc (
    input wire logic     sys_clk,
    input wire logic     rst,
    pbf_crc_if.engine    crc_port
);
    import pbf_pkg::*;

    typedef struct packed {
        logic [31:0] crc;
    } pbf_crc_state_type;

    pbf_crc_state_type st;
    pbf_crc_state_type next_st;

    // reflected crc-32, one byte per clock
    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c ^ {24'h000000, d};
        for (int i = 0; i < 8; i++)
        begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    always_comb
    begin
        next_st = st;
        if (crc_port.init)
        begin
            next_st.crc = crc_port.en ? crc_byte(CRC_INIT, crc_port.data) : CRC_INIT;
        end
        else if (crc_port.en)
        begin
            next_st.crc = crc_byte(st.crc, crc_port.data);
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            st.crc <= CRC_INIT;
        else
            st <= next_st;
    end

    assign crc_port.crc = st.crc;
endmodule
`default_nettype wire

// File: hw/pbf_framer.sv
`timescale 1ns/100ps
`default_nettype none
module pbf_framer (
    input  wire logic            sys_clk,
    input  wire logic            rst,
    input  wire logic [3:0]      host_addr,
    input  wire logic [3:0]      host_be,
    input  wire logic            host_rd,
    input  wire logic            host_wr,
    input  wire logic [31:0]     host_wdata,
    output logic      [31:0]     host_rdata,
    output logic                 host_rvalid,
    output logic      [2:0]      active_bank,
    output logic                 external_register_chip_select_n,
    input  wire logic            rx_valid,
    input  wire logic [7:0]      rx_data,
    input  wire logic            rx_last,
    input  wire logic            rx_er,
    input  wire logic            rx_align_err,
    input  wire logic [pbf_pkg::AW-1:0] rx_base,
    output logic                 rx_done,
    output logic                 rx_mcast_accept,
    input  wire logic            tx_start,
    input  wire logic [pbf_pkg::AW-1:0] tx_base,
    input  wire logic [15:0]     tx_status,
    input  wire logic            tx_ready,
    output logic                 tx_valid,
    output logic      [7:0]      tx_data,
    output logic                 tx_done,
    output logic                 mem_we,
    output logic [pbf_pkg::AW-1:0] mem_waddr,
    output logic      [15:0]     mem_wdata,
    output logic                 mem_re,
    output logic [pbf_pkg::AW-1:0] mem_raddr,
    input  wire logic [15:0]     mem_rdata
);
    import pbf_pkg::*;

    typedef struct packed {
        logic [2:0]       bank;
        logic [15:0]      transmit_control_register;
        logic [63:0]      mt;
        logic [31:0]      rdata;
        logic             rvalid;
        logic             cs_n;
        pbf_rx_state_type rx_state;
        logic [11:0]      rx_n;
        logic [AW-1:0]    rx_wbase;
        logic [7:0]       rx_lo;
        logic [5:0]       rx_hash;
        logic             rx_bcast;
        logic             rx_mcast;
        logic             rx_bad;
        logic             rx_align;
        logic             rx_odd;
        logic             rx_done;
        logic             rx_macc;
        pbf_tx_state_type tx_state;
        logic [AW-1:0]    tx_base;
        logic [AW-1:0]    tx_ptr;
        logic [10:0]      tx_left;
        logic [15:0]      tx_word;
        logic [7:0]       tx_ctl_lo;
        logic             tx_odd;
        logic             tx_append;
        logic             tx_valid;
        logic [7:0]       tx_data;
        logic [1:0]       tx_bi;
        logic             tx_done;
        logic             mem_we;
        logic [AW-1:0]    mem_waddr;
        logic [15:0]      mem_wdata;
        logic             mem_re;
        logic [AW-1:0]    mem_raddr;
    } pbf_state_type;

    pbf_state_type st;
    pbf_state_type next_st;

    pbf_crc_if crc_rx ();
    pbf_crc_if crc_tx ();

    logic tx_accept;

    function automatic logic [7:0] rd_byte(input logic [3:0] a, input logic [2:0] bk,
                                           input logic [15:0] transmit_control_register, input logic [63:0] mt);
        logic [7:0] r;
        r = 8'h00;
        if (a == OFF_BSR_HI)
            r = BSR_ID;
        else if (a == OFF_BSR_LO)
            r = {5'h00, bk};
        else if (bk == BANK_TX && a[3:1] == OFF_TCR[3:1])
            r = a[0] ? transmit_control_register[15:8] : transmit_control_register[7:0];
        else if (bk == BANK_MT && !a[3])
            r = mt[{a[2:0], 3'h0} +: 8];
        return r;
    endfunction

    // top crc bits, bit order restored from the reflected register
    function automatic logic [5:0] crc_hash(input logic [31:0] c);
        logic [5:0] h;
        h = 6'h00;
        for (int i = 0; i < 6; i++)
        begin
            h[5 - i] = c[i];
        end
        return h;
    endfunction

    assign tx_accept     = st.tx_valid && tx_ready;
    assign crc_rx.init   = rx_valid && st.rx_state == RX_IDLE;
    assign crc_rx.en     = rx_valid && (st.rx_state == RX_IDLE || st.rx_state == RX_DATA);
    assign crc_rx.data   = rx_data;
    assign crc_tx.init   = st.tx_state == TX_IDLE;
    assign crc_tx.en     = tx_accept && st.tx_state != TX_CRC;
    assign crc_tx.data   = st.tx_data;

    pbf_crc u_crc_rx (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .crc_port (crc_rx.engine)
    );

    pbf_crc u_crc_tx (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .crc_port (crc_tx.engine)
    );

    always_comb
    begin
        logic [3:0]    ba;
        logic [11:0]   idx;
        logic [11:0]   nst;
        logic [AW-1:0] base;
        logic [10:0]   words;
        logic [15:0]   stat;
        ba    = 4'h0;
        idx   = 12'h000;
        base  = st.rx_wbase;
        words = 11'h000;
        stat  = 16'h0000;
        nst   = (st.rx_n > DATA_MAX) ? DATA_MAX : st.rx_n;
        next_st = st;
        next_st.rvalid  = 1'b0;
        next_st.rx_done = 1'b0;
        next_st.rx_macc = 1'b0;
        next_st.tx_done = 1'b0;
        next_st.mem_we  = 1'b0;
        next_st.mem_re  = 1'b0;

        // host window, decoded against the bank held at cycle start
        next_st.cs_n = !((host_rd || host_wr) && st.bank == BANK_EXT && !host_addr[3]);
        next_st.rvalid = host_rd;
        for (int i = 0; i < 4; i++)
        begin
            ba = {host_addr[3:2], 2'(i)};
            if (host_rd)
                next_st.rdata[8*i +: 8] = host_be[i] ? rd_byte(ba, st.bank, st.transmit_control_register, st.mt) : 8'h00;
            if (host_wr && host_be[i])
            begin
                // a dword write at 0ch only lands on the bank select lanes
                if (ba == OFF_BSR_LO)
                    next_st.bank = host_wdata[8*i +: 3];
                else if (st.bank == BANK_TX && ba[3:1] == OFF_TCR[3:1])
                    next_st.transmit_control_register[{ba[0], 3'h0} +: 8] = host_wdata[8*i +: 8]
                                                       & TCR_MASK[{ba[0], 3'h0} +: 8];
                else if (st.bank == BANK_MT && !ba[3])
                    next_st.mt[{ba[2:0], 3'h0} +: 8] = host_wdata[8*i +: 8];
            end
        end

        // receive side: device writes the whole structure
        unique case (st.rx_state)
            RX_IDLE,
            RX_DATA:
            begin
                if (rx_valid)
                begin
                    if (st.rx_state == RX_IDLE)
                    begin
                        next_st.rx_bcast = 1'b1;
                        next_st.rx_bad   = 1'b0;
                        next_st.rx_hash  = 6'h00;
                        next_st.rx_wbase = rx_base;
                        base = rx_base;
                    end
                    else
                    begin
                        idx = st.rx_n;
                    end
                    next_st.rx_n = (idx == 12'hfff) ? idx : idx + 12'h001;
                    next_st.rx_state = rx_last ? RX_CTL : RX_DATA;
                    if (idx < DA_LEN && rx_data != 8'hff)
                        next_st.rx_bcast = 1'b0;
                    if (idx == 12'h000)
                        next_st.rx_mcast = rx_data[0];
                    if (idx == DA_LEN)
                        next_st.rx_hash = crc_hash(crc_rx.crc);
                    if (rx_er)
                        next_st.rx_bad = 1'b1;
                    if (rx_last)
                        next_st.rx_align = rx_align_err;
                    // bytes below DATA_MAX stored verbatim from offset 4
                    if (!idx[0])
                        next_st.rx_lo = rx_data;
                    else if (idx < DATA_MAX)
                    begin
                        next_st.mem_we    = 1'b1;
                        next_st.mem_waddr = base + W_DATA + {1'b0, idx[11:1]};
                        next_st.mem_wdata = {rx_data, st.rx_lo};
                    end
                end
            end
            RX_CTL:
            begin
                next_st.rx_odd = nst[0];
                next_st.rx_bad = st.rx_bad || crc_rx.crc != CRC_RES;
                next_st.mem_we    = 1'b1;
                next_st.mem_waddr = st.rx_wbase + W_DATA + {1'b0, nst[11:1]};
                next_st.mem_wdata = {RX_CTL_BASE | {2'h0, nst[0], 5'h00},
                                     nst[0] ? st.rx_lo : 8'h00};
                next_st.rx_state  = RX_CNT;
            end
            RX_CNT:
            begin
                next_st.mem_we    = 1'b1;
                next_st.mem_waddr = st.rx_wbase + W_CNT;
                // always even; odd flag carries the truth
                next_st.mem_wdata = {4'h0, nst + (st.rx_odd ? HDR_ODD : HDR_EVEN)};
                next_st.rx_state  = RX_STAT;
            end
            RX_STAT:
            begin
                stat[ST_ALGN]   = st.rx_align;
                stat[ST_BCAST]  = st.rx_bcast;
                stat[ST_CRC_ERROR_FLAG] = st.rx_bad;
                stat[ST_ODD]    = st.rx_odd;
                stat[ST_LONG]   = st.rx_n > LEN_MAX;
                stat[ST_SHORT]  = st.rx_n < LEN_MIN;
                stat[ST_HASH +: 6] = st.rx_hash;
                stat[ST_MCAST]  = st.rx_mcast;
                next_st.mem_we    = 1'b1;
                next_st.mem_waddr = st.rx_wbase + W_STAT;
                next_st.mem_wdata = stat;
                next_st.rx_done   = 1'b1;
                next_st.rx_macc   = st.rx_mcast && st.mt[st.rx_hash];
                next_st.rx_state  = RX_IDLE;
            end
        endcase

        // transmit side: host built the packet, device reads it and writes back the status word
        unique case (st.tx_state)
            TX_IDLE:
            begin
                if (tx_start)
                begin
                    next_st.tx_base   = tx_base;
                    next_st.tx_ptr    = tx_base + W_DATA;
                    next_st.mem_re    = 1'b1;
                    next_st.mem_raddr = tx_base + W_CNT;
                    next_st.tx_state  = TX_CNT;
                end
            end
            TX_CNT:
            begin
                words = mem_rdata[11:1];
                next_st.tx_left   = (words > HDR_WORDS) ? words - HDR_WORDS : 11'h000;
                next_st.mem_re    = 1'b1;
                next_st.mem_raddr = (words < HDR_WORDS) ? st.tx_ptr
                                    : st.tx_base + {1'b0, words} - 12'h001;
                next_st.tx_state  = TX_CTL;
            end
            TX_CTL:
            begin
                next_st.tx_ctl_lo = mem_rdata[7:0];
                next_st.tx_odd    = mem_rdata[8 + CTL_ODD];
                // crc by default unless suppressed, then per packet
                next_st.tx_append = !st.transmit_control_register[TCR_CRC_SUPPRESS] || mem_rdata[8 + CTL_CRC];
                next_st.tx_state  = TX_NEXT;
            end
            TX_NEXT:
            begin
                next_st.tx_bi = 2'h0;
                if (st.tx_left != 11'h000)
                begin
                    next_st.mem_re    = 1'b1;
                    next_st.mem_raddr = st.tx_ptr;
                    next_st.tx_state  = TX_WORD;
                end
                else if (st.tx_odd)
                begin
                    next_st.tx_valid = 1'b1;
                    next_st.tx_data  = st.tx_ctl_lo;
                    next_st.tx_state = TX_ODD;
                end
                else
                    next_st.tx_state = st.tx_append ? TX_CRC : TX_STAT;
            end
            TX_WORD:
            begin
                next_st.tx_word  = mem_rdata;
                next_st.tx_valid = 1'b1;
                next_st.tx_data  = mem_rdata[7:0];
                next_st.tx_state = TX_LO;
            end
            TX_LO:
            begin
                if (tx_accept)
                begin
                    next_st.tx_data  = st.tx_word[15:8];
                    next_st.tx_state = TX_HI;
                end
            end
            TX_HI:
            begin
                if (tx_accept)
                begin
                    next_st.tx_valid = 1'b0;
                    next_st.tx_left  = st.tx_left - 11'h001;
                    next_st.tx_ptr   = st.tx_ptr + 12'h001;
                    next_st.tx_state = TX_NEXT;
                end
            end
            TX_ODD:
            begin
                if (tx_accept)
                begin
                    next_st.tx_valid = 1'b0;
                    next_st.tx_state = st.tx_append ? TX_CRC : TX_STAT;
                end
            end
            TX_CRC:
            begin
                // bubble before each fcs byte lets the crc settle first
                if (!st.tx_valid)
                begin
                    next_st.tx_valid = 1'b1;
                    next_st.tx_data  = ~crc_tx.crc[{st.tx_bi, 3'h0} +: 8];
                end
                else if (tx_accept)
                begin
                    next_st.tx_valid = 1'b0;
                    next_st.tx_bi    = st.tx_bi + 2'h1;
                    if (st.tx_bi == 2'h3)
                        next_st.tx_state = TX_STAT;
                end
            end
            TX_STAT:
            begin
                // receive owns the write port; status waits until receive leaves it free
                if (!next_st.mem_we)
                begin
                    next_st.mem_we    = 1'b1;
                    next_st.mem_waddr = st.tx_base + W_STAT;
                    next_st.mem_wdata = tx_status;
                    next_st.tx_done   = 1'b1;
                    next_st.tx_state  = TX_IDLE;
                end
            end
            default:
                next_st.tx_state = TX_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            st      <= '0;
            st.bank <= BANK_RST;
            st.transmit_control_register  <= TCR_RST;
            st.cs_n <= 1'b1;
        end
        else
            st <= next_st;
    end

    assign host_rdata  = st.rdata;
    assign host_rvalid = st.rvalid;
    assign active_bank = st.bank;
    assign external_register_chip_select_n = st.cs_n;
    assign rx_done         = st.rx_done;
    assign rx_mcast_accept = st.rx_macc;
    assign tx_valid  = st.tx_valid;
    assign tx_data   = st.tx_data;
    assign tx_done   = st.tx_done;
    assign mem_we    = st.mem_we;
    assign mem_waddr = st.mem_waddr;
    assign mem_wdata = st.mem_wdata;
    assign mem_re    = st.mem_re;
    assign mem_raddr = st.mem_raddr;

    default clocking pbf_cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    bsr_id_read_a: assert property (
        host_rd && host_be[3] && host_addr[3:2] == 2'h3 |=> host_rvalid && host_rdata[31:24] == 8'h33)
        else $error("bank select upper byte not 33h");

    bank_write_a: assert property (
        host_wr && host_be[2] && host_addr[3:2] == 2'h3 |=> active_bank == $past(host_wdata[18:16]))
        else $error("bank select write lost");

    ext_cs_a: assert property (
        (host_rd || host_wr) |=> external_register_chip_select_n ==
            !($past(active_bank) == 3'h7 && !$past(host_addr[3])))
        else $error("external chip select wrong");

    rx_ctl_byte_a: assert property (
        st.rx_state == RX_CTL |=> mem_we && mem_wdata[15:14] == 2'h1 && mem_wdata[12:8] == 5'h00)
        else $error("receive control byte malformed");

    rx_even_count_a: assert property (
        st.rx_state == RX_CNT |=> mem_we && !mem_wdata[0] && mem_waddr == st.rx_wbase + 12'h001)
        else $error("receive count odd or misplaced");

    rx_status_a: assert property (
        st.rx_state == RX_STAT |=> mem_we && mem_waddr == $past(st.rx_wbase) && rx_done
            ##1 !rx_done)
        else $error("receive status word not written");

    rx_crc_err_a: assert property (
        (st.rx_state == RX_IDLE || st.rx_state == RX_DATA) && rx_valid && rx_er |=> st.rx_bad)
        else $error("receive error did not flag crc");

    tx_append_a: assert property (
        st.tx_state == TX_CTL |=> st.tx_append == (!st.transmit_control_register[8] || $past(mem_rdata[12])))
        else $error("crc append decision wrong");

    tx_odd_byte_a: assert property (
        st.tx_state == TX_ODD |-> st.tx_odd && tx_valid && tx_data == st.tx_ctl_lo)
        else $error("odd trailing byte wrong");
endmodule
`default_nettype wire

// File: test/pbf_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module pbf_mem_model (
    input  wire logic        sys_clk,
    input  wire logic        we,
    input  wire logic [11:0] waddr,
    input  wire logic [15:0] wdata,
    input  wire logic        re,
    input  wire logic [11:0] raddr,
    output logic      [15:0] rdata
);
    logic [15:0] mem [0:4095];
    // outside a read the bus shows junk, so a stale word cannot pass
    assign rdata = re ? mem[raddr] : ~mem[raddr];
    always @(posedge sys_clk)
    begin
        if (we)
            mem[waddr] <= wdata;
    end
endmodule
`default_nettype wire

// File: test/pbf_framer_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) \
    begin \
        samples_checked++; \
        if ((a) !== (b)) \
        begin \
            num_errors++; \
            $display("FAIL %0t got %0h exp %0h", $time, a, b); \
        end \
    end
module pbf_framer_tb;
    import pbf_pkg::*;
    logic        sys_clk, rst, host_rd, host_wr, rx_valid, rx_last, rx_er, rx_align_err;
    logic        tx_start, tx_ready, tx_valid, tx_done, rx_done, rx_mcast_accept;
    logic        host_rvalid, external_register_chip_select_n, mem_we, mem_re;
    logic [3:0]  host_addr, host_be;
    logic [31:0] host_wdata, host_rdata, rd;
    logic [11:0] rx_base, tx_base, mem_waddr, mem_raddr;
    logic [15:0] tx_status, mem_wdata, mem_rdata;
    logic [7:0]  rx_data, tx_data;
    logic [2:0]  active_bank;
    logic [7:0]  got [0:15];
    logic [7:0]  ctls [0:2] = '{8'h20, 8'h00, 8'h30};
    int          exp_n [0:2] = '{3, 2, 7};
    int          num_errors, samples_checked, n_tx, i;
    int          cyc = 0;

    pbf_framer dut (.sys_clk, .rst, .host_addr, .host_be, .host_rd, .host_wr, .host_wdata,
        .host_rdata, .host_rvalid, .active_bank, .external_register_chip_select_n,
        .rx_valid, .rx_data, .rx_last, .rx_er, .rx_align_err, .rx_base, .rx_done,
        .rx_mcast_accept, .tx_start, .tx_base, .tx_status, .tx_ready, .tx_valid, .tx_data,
        .tx_done, .mem_we, .mem_waddr, .mem_wdata, .mem_re, .mem_raddr, .mem_rdata);
    pbf_mem_model u_mem (.sys_clk(sys_clk), .we(mem_we), .waddr(mem_waddr),
        .wdata(mem_wdata), .re(mem_re), .raddr(mem_raddr), .rdata(mem_rdata));

    initial
    begin
        sys_clk = 0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic results;
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic acc(input logic w, input logic [3:0] a, be, input logic [31:0] d);
        @(posedge sys_clk);
        host_wr <= w;
        host_rd <= ~w;
        host_addr <= a;
        host_be <= be;
        host_wdata <= d;
        @(posedge sys_clk);
        host_wr <= 0;
        host_rd <= 0;
        #1 rd = host_rdata;
        if (!w)
            `CHK(host_rvalid, 1'b1)
    endtask

    task automatic rxb(input logic [7:0] d, input logic l);
        @(posedge sys_clk);
        rx_valid <= 1;
        rx_data <= d;
        rx_last <= l;
        @(posedge sys_clk);
        rx_valid <= 0;
    endtask

    // extra edge lets the final memory write land
    task automatic wdone(input logic tx);
        logic seen;
        seen = 1'b0;
        repeat (200)
        begin
            @(posedge sys_clk);
            #1;
            if (tx ? tx_done : rx_done)
            begin
                seen = 1'b1;
                break;
            end
        end
        `CHK(seen, 1'b1)
        @(posedge sys_clk);
        #1;
    endtask

    // consumer stalls every other cycle
    always @(posedge sys_clk)
    begin
        tx_ready <= ~tx_ready;
        cyc <= cyc + 1;
        if (tx_valid && tx_ready)
        begin
            got[n_tx[3:0]] <= tx_data;
            n_tx <= n_tx + 1;
        end
        if (cyc == 5000)
        begin
            num_errors++;
            results;
        end
    end

    initial
    begin
        rst = 1;
        {host_rd, host_wr, rx_valid, rx_last, rx_er, rx_align_err, tx_start, tx_ready} = '0;
        {host_addr, host_be, host_wdata, rx_data, rx_base, tx_base, tx_status} = '0;
        repeat (8) @(posedge sys_clk);
        rst <= 0;
        acc(0, 4'hc, 4'b1100, 32'h0);
        `CHK(rd[31:24], BSR_ID)
        `CHK(rd[18:16], BANK_RST)
        acc(1, 4'hc, 4'b1111, 32'h5503_aaaa);
        `CHK(active_bank, BANK_MT)
        acc(1, 4'h4, 4'b1111, 32'h8877_6655);
        acc(1, 4'h1, 4'b0010, 32'h0000_1100);
        acc(0, 4'h4, 4'b1111, 32'h0);
        `CHK(rd, 32'h8877_6655)
        acc(0, 4'h0, 4'b0010, 32'h0);
        `CHK(rd, 32'h0000_1100)
        acc(1, 4'hc, 4'b0100, 32'h0007_0000);
        acc(1, 4'h0, 4'b0011, 32'h0);
        `CHK(external_register_chip_select_n, 1'b0)
        acc(1, 4'h8, 4'b0011, 32'h0);
        `CHK(external_register_chip_select_n, 1'b1)
        $display("bank test done");
        rx_base <= 12'h100;
        rx_er <= 1;
        rxb(8'h11, 0);
        rx_er <= 0;
        rxb(8'h22, 0);
        rxb(8'h33, 1);
        wdone(0);
        `CHK(u_mem.mem[12'h101], 16'h0008)
        `CHK(u_mem.mem[12'h102], 16'h2211)
        `CHK(u_mem.mem[12'h103], 16'h6033)
        `CHK(u_mem.mem[12'h100][ST_ODD], 1'b1)
        `CHK(u_mem.mem[12'h100][ST_SHORT], 1'b1)
        `CHK(u_mem.mem[12'h100][ST_CRC_ERROR_FLAG], 1'b1)
        `CHK(u_mem.mem[12'h100][ST_MCAST], 1'b1)
        $display("rx test done");
        acc(1, 4'hc, 4'b0100, 32'h0);
        acc(1, 4'h0, 4'b0010, 32'h0000_0100);
        for (i = 0; i < 3; i++)
        begin
            u_mem.mem[12'h201] = 16'h0009;
            u_mem.mem[12'h202] = 16'hb2a1;
            u_mem.mem[12'h203] = {ctls[i], 8'hc3};
            n_tx = 0;
            tx_base <= 12'h200;
            tx_status <= 16'h0123;
            @(posedge sys_clk);
            tx_start <= 1;
            @(posedge sys_clk);
            tx_start <= 0;
            wdone(1);
            `CHK(n_tx, exp_n[i])
            `CHK(got[0], 8'ha1)
            `CHK(got[1], 8'hb2)
            if (i != 1)
                `CHK(got[2], 8'hc3)
            `CHK(u_mem.mem[12'h200], 16'h0123)
        end
        $display("tx test done");
        results;
    end
endmodule
`default_nettype wire
